// [include/rwcf_params.svh]
// constants of the readout word checksum and number formats
// assumes inclusion by bare name from the package and design files
`ifndef RWCF_PARAMS_SVH
`define RWCF_PARAMS_SVH

// checksum: polynomial, start value, final xor
`define RWCF_CRC_POLY 8'h31
`define RWCF_CRC_INIT 8'hFF
`define RWCF_CRC_XOROUT 8'h00

// flow format for oxygen, air and mixture 0
`define RWCF_FLOW_SCALE 16'h00AA
`define RWCF_FLOW_OFFSET 16'hA000
// temperature format
`define RWCF_TEMP_SCALE 16'h00C8
`define RWCF_TEMP_OFFSET 16'h0000

// flow-unit word field positions
`define RWCF_UNIT_PFX_LSB 0
`define RWCF_UNIT_PFX_MSB 3
`define RWCF_UNIT_TB_LSB 4
`define RWCF_UNIT_TB_MSB 7
`define RWCF_UNIT_BASE_LSB 8
`define RWCF_UNIT_BASE_MSB 12
// field values of standard litres per minute
`define RWCF_UNIT_PFX_ONE 4'h8
`define RWCF_UNIT_TB_MIN 4'h4
`define RWCF_UNIT_BASE_SL 5'h01

// word fifo depth and data width
`define RWCF_FIFO_DEPTH 8
`define RWCF_WORD_W 16

`endif

// [include/rwcf_pkg.sv]
// types and checksum/format functions shared by both ends
// assumes rwcf_params.svh is on the include path
`include "rwcf_params.svh"

package rwcf_pkg;

	// calibrated signal selection
	typedef enum logic [2:0] {
		RWCF_GAS_O2 = 3'b000,
		RWCF_GAS_AIR = 3'b001,
		RWCF_GAS_RSV2 = 3'b010,
		RWCF_GAS_RSV3 = 3'b011,
		RWCF_GAS_RSV4 = 3'b100,
		RWCF_GAS_RSV5 = 3'b101,
		RWCF_MIX_0 = 3'b110,
		RWCF_MIX_1 = 3'b111
	} rwcf_gas_t;

	// how the host interprets a received word
	typedef enum logic [1:0] {
		RWCF_KIND_RAW = 2'b00,
		RWCF_KIND_FLOW = 2'b01,
		RWCF_KIND_TEMP = 2'b10,
		RWCF_KIND_UNIT = 2'b11
	} rwcf_kind_t;

	typedef struct packed {
		logic valid;
		logic [15:0] unit;
		logic [15:0] scale;
		logic [15:0] offset;
	} rwcf_fmt_t;

	// one byte through the msb-first crc, no reflection
	function automatic logic [7:0] rwcf_crc8(input logic [7:0] crc, input logic [7:0] data);
		logic [7:0] c;
		c = crc ^ data;
		for (int i = 0; i < 8; i++) begin
			c = c[7] ? ((c << 1) ^ `RWCF_CRC_POLY) : (c << 1);
		end
		return c;
	endfunction : rwcf_crc8

	// checksum of one 16-bit word, fresh start value each time
	function automatic logic [7:0] rwcf_word_crc(input logic [15:0] w);
		return rwcf_crc8(rwcf_crc8(`RWCF_CRC_INIT, w[15:8]), w[7:0]) ^ `RWCF_CRC_XOROUT;
	endfunction : rwcf_word_crc

	// format of the selected gas; reserved slots come back invalid
	function automatic rwcf_fmt_t rwcf_gas_fmt(input rwcf_gas_t g);
		rwcf_fmt_t f;
		f.unit = 16'h0000;
		f.unit[`RWCF_UNIT_PFX_MSB:`RWCF_UNIT_PFX_LSB] = `RWCF_UNIT_PFX_ONE;
		f.unit[`RWCF_UNIT_TB_MSB:`RWCF_UNIT_TB_LSB] = `RWCF_UNIT_TB_MIN;
		f.unit[`RWCF_UNIT_BASE_MSB:`RWCF_UNIT_BASE_LSB] = `RWCF_UNIT_BASE_SL;
		f.scale = `RWCF_FLOW_SCALE;
		f.offset = `RWCF_FLOW_OFFSET;
		f.valid = (g == RWCF_GAS_O2) || (g == RWCF_GAS_AIR) || (g == RWCF_MIX_0);
		if (!f.valid) begin
			f.unit = 16'h0000;
			f.scale = 16'h0000;
			f.offset = 16'h0000;
		end
		return f;
	endfunction : rwcf_gas_fmt

endpackage : rwcf_pkg

// [include/rwcf_link_if.sv]
// byte link between the sensor end and the reading end
// assumes both ends run on the same clock as the interface
`timescale 1ns/1ps

interface rwcf_link_if (
	input logic i_clk
);
	logic [7:0] data; // byte on the link
	logic valid; // byte offered
	logic first; // first byte of a response
	logic ready; // reader takes the byte

	modport dev (
		output data,
		output valid,
		output first,
		input ready
	);
	modport host (
		input data,
		input valid,
		input first,
		output ready
	);
endinterface : rwcf_link_if

// [hw/rwcf_dev.sv]
// sensor end: word fifo, then msb-first bytes with a checksum after each word
// assumes the reader keeps ready asserted or holds it low only between bytes
`timescale 1ns/1ps
`include "rwcf_params.svh"

module rwcf_fifo #(
	parameter int W = 17,
	parameter int DEPTH = `RWCF_FIFO_DEPTH
) (
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic [W-1:0] i_data,
	input wire logic i_valid,
	output logic o_ready,
	output logic [W-1:0] o_data,
	output logic o_valid,
	input wire logic i_ready
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);

	if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
		$error("fifo depth must be a power of two of at least 2");
	end
	if (W < 1) begin : g_bad_width
		$error("fifo width must be at least 1");
	end

	logic [W-1:0] mem [DEPTH];
	logic [AW-1:0] wptr;
	logic [AW-1:0] rptr;
	logic [CW-1:0] count;
	logic not_full;
	logic [CW-1:0] next_count;
	wire push = i_valid & not_full;
	wire pop = o_valid & i_ready;

	// flags and read side
	assign o_valid = (count != '0);
	assign o_data = mem[rptr];
	assign o_ready = not_full;
	assign next_count = (push && !pop) ? count + CW'(1) : ((!push && pop) ? count - CW'(1) : count);

	// pointers, count and registered not-full
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			wptr <= '0;
			rptr <= '0;
			count <= '0;
			not_full <= 1'b1;
		end else begin
			if (push) begin
				wptr <= wptr + AW'(1);
			end
			if (pop) begin
				rptr <= rptr + AW'(1);
			end
			count <= next_count;
			not_full <= (next_count != CW'(DEPTH));
		end
	end

	// storage
	always_ff @(posedge i_clk) begin
		if (push) begin
			mem[wptr] <= i_data;
		end
	end
endmodule : rwcf_fifo

module rwcf_dev #(
	parameter int DEPTH = `RWCF_FIFO_DEPTH
) (
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic [15:0] i_word,
	input wire logic i_word_first,
	input wire logic i_word_valid,
	output logic o_word_ready,
	input wire rwcf_pkg::rwcf_gas_t i_gas_sel,
	output logic o_fmt_valid,
	output logic [15:0] o_flow_unit,
	output logic [15:0] o_flow_scale,
	output logic [15:0] o_flow_offset,
	output logic [15:0] o_temp_scale,
	output logic [15:0] o_temp_offset,
	output logic o_busy,
	rwcf_link_if.dev link
);
	typedef enum logic [1:0] {
		RWCF_S_IDLE = 2'b00,
		RWCF_S_HI = 2'b01,
		RWCF_S_LO = 2'b10,
		RWCF_S_CRC = 2'b11
	} rwcf_tx_state_t;

	rwcf_tx_state_t state;
	logic [15:0] word;
	logic [7:0] crc;
	logic [7:0] tx_data;
	logic tx_valid;
	logic tx_first;
	logic [16:0] q_data;
	logic q_valid;
	rwcf_pkg::rwcf_fmt_t fmt;

	// byte accepted, and fetch of the next word; ahead of the queue that reads load
	wire taken = tx_valid & link.ready;
	wire load = q_valid & ((state == RWCF_S_IDLE) | ((state == RWCF_S_CRC) & taken));
	wire drain = (state == RWCF_S_CRC) & taken & ~q_valid;

	// word queue; its not-full is the user's ready
	// one word waits in the sender, so the user may push one beyond the depth
	rwcf_fifo #(
		.W(17),
		.DEPTH(DEPTH)
	) rwcf_fifo_inst (
		.i_clk(i_clk),
		.i_reset(i_reset),
		.i_data({i_word_first, i_word}),
		.i_valid(i_word_valid),
		.o_ready(o_word_ready),
		.o_data(q_data),
		.o_valid(q_valid),
		.i_ready(load)
	);

	wire [7:0] next_crc = rwcf_pkg::rwcf_word_crc(q_data[15:0]);
	assign fmt = rwcf_pkg::rwcf_gas_fmt(i_gas_sel);

	// link pins from flops
	assign link.data = tx_data;
	assign link.valid = tx_valid;
	assign link.first = tx_first;

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			state <= RWCF_S_IDLE;
			word <= 16'h0000;
			crc <= 8'h00;
			tx_data <= 8'h00;
			tx_valid <= 1'b0;
			tx_first <= 1'b0;
		end else if (load) begin
			// word sent as given, msb first
			word <= q_data[15:0];
			crc <= next_crc;
			tx_data <= q_data[15:8];
			tx_first <= q_data[16];
			tx_valid <= 1'b1;
			state <= RWCF_S_HI;
		end else if (drain) begin
			tx_valid <= 1'b0;
			state <= RWCF_S_IDLE;
		end else if (taken) begin
			tx_first <= 1'b0;
			unique case (state)
				RWCF_S_HI: begin
					tx_data <= word[7:0];
					state <= RWCF_S_LO;
				end
				RWCF_S_LO: begin
					tx_data <= crc;
					state <= RWCF_S_CRC;
				end
				RWCF_S_IDLE, RWCF_S_CRC: begin
					state <= state;
				end
			endcase
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			o_fmt_valid <= 1'b0;
			o_flow_unit <= 16'h0000;
			o_flow_scale <= 16'h0000;
			o_flow_offset <= 16'h0000;
			o_temp_scale <= 16'h0000;
			o_temp_offset <= 16'h0000;
			o_busy <= 1'b0;
		end else begin
			o_fmt_valid <= fmt.valid;
			o_flow_unit <= fmt.unit;
			o_flow_scale <= fmt.scale;
			o_flow_offset <= fmt.offset;
			o_temp_scale <= `RWCF_TEMP_SCALE;
			o_temp_offset <= `RWCF_TEMP_OFFSET;
			o_busy <= q_valid | (state != RWCF_S_IDLE);
		end
	end
endmodule : rwcf_dev

// [hw/rwcf_host.sv]
// reading end: collects byte pairs, checks each checksum, converts good temperature words and good flow words of a valid gas
// assumes the sensor end marks a response's first byte with first
`timescale 1ns/1ps
`include "rwcf_params.svh"

module rwcf_host (
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic i_hold,
	input wire rwcf_pkg::rwcf_gas_t i_gas_sel,
	input wire rwcf_pkg::rwcf_kind_t i_kind,
	output logic [15:0] o_word,
	output logic o_word_valid,
	output logic o_word_first,
	output logic o_crc_error,
	output logic signed [16:0] o_diff,
	output logic signed [15:0] o_phys,
	output logic o_fmt_valid,
	rwcf_link_if.host link
);
	logic [1:0] pos;
	logic [7:0] hi;
	logic [7:0] lo;
	logic pair_first;
	logic rx_ready;
	rwcf_pkg::rwcf_fmt_t fmt;

	// byte taken and its place within the group of three
	wire take = link.valid & rx_ready;
	wire [1:0] eff_pos = link.first ? 2'h0 : pos;
	wire [7:0] expect_crc = rwcf_pkg::rwcf_word_crc({hi, lo});
	wire crc_ok = (link.data == expect_crc);
	wire check = take & (eff_pos == 2'h2);
	assign fmt = rwcf_pkg::rwcf_gas_fmt(i_gas_sel);

	// offset and scale of the chosen kind
	wire [15:0] sel_off = (i_kind == rwcf_pkg::RWCF_KIND_TEMP) ? `RWCF_TEMP_OFFSET : fmt.offset;
	wire [15:0] sel_scale = (i_kind == rwcf_pkg::RWCF_KIND_TEMP) ? `RWCF_TEMP_SCALE : fmt.scale;
	wire conv = (i_kind == rwcf_pkg::RWCF_KIND_TEMP) | ((i_kind == rwcf_pkg::RWCF_KIND_FLOW) & fmt.valid);
	wire signed [16:0] next_diff = $signed({hi[7], hi, lo}) - $signed({sel_off[15], sel_off});
	wire signed [16:0] quot = conv ? (next_diff / $signed({1'b0, sel_scale})) : 17'sh00000;
	assign link.ready = rx_ready;

	// byte collection; each check uses only its own pair
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			pos <= 2'h0;
			hi <= 8'h00;
			lo <= 8'h00;
			pair_first <= 1'b0;
			rx_ready <= 1'b0;
		end else begin
			rx_ready <= ~i_hold;
			if (take) begin
				unique case (eff_pos)
					2'h0: begin
						hi <= link.data;
						pair_first <= link.first;
						pos <= 2'h1;
					end
					2'h1: begin
						lo <= link.data;
						pos <= 2'h2;
					end
					2'h2: begin
						pos <= 2'h0;
					end
					default: begin
						pos <= 2'h0;
					end
				endcase
			end
		end
	end

	// deliver good words, flag and drop bad ones
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			o_word <= 16'h0000;
			o_word_valid <= 1'b0;
			o_word_first <= 1'b0;
			o_crc_error <= 1'b0;
			o_diff <= 17'sh00000;
			o_phys <= 16'sh0000;
			o_fmt_valid <= 1'b0;
		end else begin
			o_word_valid <= check & crc_ok;
			o_crc_error <= check & ~crc_ok;
			o_fmt_valid <= conv;
			if (check & crc_ok) begin
				o_word <= {hi, lo};
				o_word_first <= pair_first;
				o_diff <= conv ? next_diff : 17'sh00000;
				o_phys <= quot[15:0];
			end
		end
	end
endmodule : rwcf_host

// [dv/rwcf_link_sva.sv]
// bench checksum helper and checker of the byte link between the two ends
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps

package rwcf_dv_pkg;
	// word checksum, msb first, poly 31, start FF, no reflection
	function automatic logic [7:0] rwcf_dv_crc(input logic [15:0] w);
		logic [7:0] c;
		c = 8'hFF;
		for (int i = 15; i >= 0; i--) begin
			c = (c[7] ^ w[i]) ? ((c << 1) ^ 8'h31) : (c << 1);
		end
		return c;
	endfunction : rwcf_dv_crc
endpackage : rwcf_dv_pkg

module rwcf_link_sva (
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic [7:0] data,
	input wire logic valid,
	input wire logic first,
	input wire logic ready
);
	logic [1:0] pos;
	logic [7:0] hi;
	logic [7:0] lo;
	wire take = valid && ready;
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_reset);
	// byte position: high, low, checksum
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			pos <= 2'h0;
		end else if (take) begin
			pos <= (pos == 2'h2) ? 2'h0 : pos + 2'h1;
		end
	end
	// bytes of the word under check
	always_ff @(posedge i_clk) begin
		if (take && pos == 2'h0) hi <= data;
		if (take && pos == 2'h1) lo <= data;
	end
	property p_hold_valid;
		valid && !ready |=> valid;
	endproperty
	a_hold_valid: assert property (p_hold_valid) else $error("valid dropped");
	property p_hold_data;
		valid && !ready |=> $stable(data);
	endproperty
	a_hold_data: assert property (p_hold_data) else $error("data moved");
	property p_hold_first;
		valid && !ready |=> $stable(first);
	endproperty
	a_hold_first: assert property (p_hold_first) else $error("first moved");
	property p_word_run;
		take && pos != 2'h2 |=> valid && !first;
	endproperty
	a_word_run: assert property (p_word_run) else $error("gap inside word");
	property p_crc;
		valid && pos == 2'h2 |-> data == rwcf_dv_pkg::rwcf_dv_crc({hi, lo});
	endproperty
	a_crc: assert property (p_crc) else $error("bad checksum byte");
	property p_first_pos;
		valid && first |-> pos == 2'h0;
	endproperty
	a_first_pos: assert property (p_first_pos) else $error("first off msb");
	property p_rst;
		$fell(i_reset) |-> !valid && !first && !ready;
	endproperty
	a_rst: assert property (p_rst) else $error("link busy after reset");
	property p_crc_after;
		take && pos == 2'h1 |=> valid ##0 pos == 2'h2;
	endproperty
	a_crc_after: assert property (p_crc_after) else $error("no checksum after word");
endmodule : rwcf_link_sva

// [dv/rwcf_bench.sv]
// bench: sensor end and reading end back to back, plus a bench-fed reading end
// assumes design, package, interface and checker compiled first
`timescale 1ns/1ps
`include "rwcf_params.svh"

module rwcf_bench;
	logic i_clk = 1'b0;
	logic i_reset = 1'b1;
	logic [15:0] i_word = 16'h0000;
	logic i_word_first = 1'b0;
	logic i_word_valid = 1'b0;
	logic hold = 1'b0;
	rwcf_pkg::rwcf_gas_t gas = rwcf_pkg::RWCF_GAS_O2;
	rwcf_pkg::rwcf_kind_t kind = rwcf_pkg::RWCF_KIND_RAW;
	logic o_word_ready, f_valid, h_valid, h_err, h2_valid, h2_err, busy, h_first, h_fmt;
	logic [15:0] f_unit, f_scale, f_off, t_scale, t_off, h_word, h2_word;
	logic signed [16:0] h_diff;
	logic signed [15:0] h_phys;
	int n_fail = 0;
	int samples_checked = 0;
	int cycles = 0;
	rwcf_link_if link (.i_clk(i_clk));
	rwcf_link_if link2 (.i_clk(i_clk));
	rwcf_dev rwcf_dev_inst (.i_clk(i_clk), .i_reset(i_reset), .i_word(i_word), .i_word_first(i_word_first),
		.i_word_valid(i_word_valid), .o_word_ready(o_word_ready), .i_gas_sel(gas), .o_fmt_valid(f_valid),
		.o_flow_unit(f_unit), .o_flow_scale(f_scale), .o_flow_offset(f_off), .o_temp_scale(t_scale),
		.o_temp_offset(t_off), .o_busy(busy), .link(link.dev));
	rwcf_host rwcf_host_inst (.i_clk(i_clk), .i_reset(i_reset), .i_hold(hold), .i_gas_sel(gas), .i_kind(kind),
		.o_word(h_word), .o_word_valid(h_valid), .o_word_first(h_first), .o_crc_error(h_err), .o_diff(h_diff),
		.o_phys(h_phys), .o_fmt_valid(h_fmt), .link(link.host));
	rwcf_host rwcf_host_inst_b (.i_clk(i_clk), .i_reset(i_reset), .i_hold(1'b0), .i_gas_sel(gas),
		.i_kind(rwcf_pkg::RWCF_KIND_RAW), .o_word(h2_word), .o_word_valid(h2_valid), .o_word_first(),
		.o_crc_error(h2_err), .o_diff(), .o_phys(), .o_fmt_valid(), .link(link2.host));
	rwcf_link_sva rwcf_link_sva_inst (.i_clk(i_clk), .i_reset(i_reset), .data(link.data), .valid(link.valid),
		.first(link.first), .ready(link.ready));
	// clock and hang guard
	initial begin
		forever #5 i_clk = ~i_clk;
	end
	always @(posedge i_clk) begin
		cycles++;
		if (cycles == 8000) begin
			n_fail++;
			complete_run();
		end
	end
	task automatic chk(input logic [16:0] got, input logic [16:0] exp, input string what);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk
	task automatic push(input logic [15:0] w, input logic f);
		@(posedge i_clk);
		i_word <= w;
		i_word_first <= f;
		i_word_valid <= 1'b1;
		do @(negedge i_clk); while (!o_word_ready);
		@(posedge i_clk);
		i_word_valid <= 1'b0;
	endtask : push
	task automatic rx(input logic [15:0] w);
		int n = 0;
		while (h_valid !== 1'b1 && n < 100) begin
			@(negedge i_clk);
			n++;
		end
		chk({h_valid, h_word}, {1'b1, w}, "word");
		@(negedge i_clk);
	endtask : rx
	task automatic send2(input logic [7:0] b, input logic f);
		@(posedge i_clk);
		link2.data <= b;
		link2.first <= f;
		link2.valid <= 1'b1;
		do @(negedge i_clk); while (!link2.ready);
		@(posedge i_clk);
		link2.valid <= 1'b0;
		link2.data <= ~b;
	endtask : send2
	task automatic t_crc();
		logic [15:0] tbl [5] = '{16'hBEEF, 16'h0000, 16'hFFFF, 16'h8000, 16'h7FFF};
		chk({9'h000, rwcf_dv_pkg::rwcf_dv_crc(16'hBEEF)}, 17'h00092, "crc example");
		fork
			foreach (tbl[i]) push(tbl[i], i == 0);
			foreach (tbl[i]) rx(tbl[i]);
		join
		$display("t_crc done");
	endtask : t_crc
	task automatic t_fill();
		int n = 0;
		@(posedge i_clk);
		hold <= 1'b1;
		while (n < 12) begin
			@(negedge i_clk);
			if (!o_word_ready) break;
			push(16'h1000 + 16'(n), n == 0);
			n++;
		end
		// the sender holds one word beside the full fifo
		chk({1'b0, 16'(n)}, {1'b0, 16'(`RWCF_FIFO_DEPTH + 1)}, "fifo fill");
		chk({16'h0000, busy}, 17'h00001, "busy while held");
		@(posedge i_clk);
		hold <= 1'b0;
		for (int i = 0; i < n; i++) begin
			rx(16'h1000 + 16'(i));
			chk({16'h0000, h_first}, {16'h0000, i == 0}, "first word");
		end
		chk({16'h0000, busy}, 17'h00000, "idle after drain");
		$display("t_fill done");
	endtask : t_fill
	task automatic t_fmt();
		logic ok;
		for (int g = 0; g < 8; g++) begin
			@(posedge i_clk);
			gas <= rwcf_pkg::rwcf_gas_t'(g[2:0]);
			repeat (2) @(negedge i_clk);
			ok = (g == 0 || g == 1 || g == 6);
			chk({f_valid, f_unit}, ok ? 17'h10148 : 17'h00000, "unit");
			chk({f_scale, 1'b0}, ok ? 17'h00154 : 17'h00000, "scale");
			chk({f_off, 1'b0}, ok ? 17'h14000 : 17'h00000, "offset");
			chk({1'b0, t_scale}, 17'h000C8, "temp scale");
			chk({1'b0, t_off}, 17'h00000, "temp offset");
		end
		$display("t_fmt done");
	endtask : t_fmt
	task automatic t_conv();
		logic [15:0] tbl [4] = '{16'h8000, 16'h7FFF, 16'hA000, 16'hFFFF};
		int d;
		int p;
		int s;
		for (int k = 0; k < 4; k++) begin
			@(posedge i_clk);
			gas <= rwcf_pkg::RWCF_GAS_AIR;
			kind <= rwcf_pkg::rwcf_kind_t'(k[1:0]);
			foreach (tbl[i]) begin
				// raw and unit words pass through with no conversion
				s = $signed(tbl[i]);
				d = (k == 1) ? s + 24576 : ((k == 2) ? s : 0);
				p = (k == 1) ? d / 170 : ((k == 2) ? d / 200 : 0);
				fork
					push(tbl[i], 1'b1);
					rx(tbl[i]);
				join
				chk(h_diff, d[16:0], "diff");
				chk({h_phys[15], h_phys}, p[16:0], "phys");
				chk({16'h0000, h_fmt}, {16'h0000, k == 1 || k == 2}, "converted");
			end
		end
		$display("t_conv done");
	endtask : t_conv
	task automatic t_bad();
		logic [1:0] seen;
		logic [15:0] w;
		for (int e = 0; e < 2; e++) begin
			seen = 2'h0;
			// the second word has a bad checksum and must not replace the first
			w = (e == 0) ? 16'h1234 : 16'h5678;
			send2(w[15:8], 1'b1);
			send2(w[7:0], 1'b0);
			send2(rwcf_dv_pkg::rwcf_dv_crc(w) ^ e[7:0], 1'b0);
			repeat (3) begin
				@(negedge i_clk);
				seen |= {h2_err, h2_valid};
			end
			chk({15'h0000, seen}, e == 1 ? 17'h00002 : 17'h00001, "crc flag");
			chk({1'b0, h2_word}, 17'h01234, "kept word");
		end
		$display("t_bad done");
	endtask : t_bad
	task automatic complete_run();
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : complete_run
	// reset, then the scenarios in turn
	initial begin
		link2.data = 8'h00;
		link2.valid = 1'b0;
		link2.first = 1'b0;
		repeat (12) @(posedge i_clk);
		i_reset <= 1'b0;
		repeat (2) @(posedge i_clk);
		t_crc();
		t_fill();
		t_fmt();
		t_conv();
		t_bad();
		complete_run();
	end
endmodule : rwcf_bench
